// ---- core/diag_flag_pkg.sv ----
// Package with the offsets, field positions, reset values and carriers of the flag group.
package diag_flag_pkg;

   // Byte offsets of the group in the enhanced management page.
   localparam logic [7:0] ALARM_FLAGS_MAIN_OFS        = 8'h70;
   localparam logic [7:0] ALARM_FLAGS_RX_POWER_OFS    = 8'h71;
   localparam logic [7:0] TX_INPUT_EQUALIZER_CTRL_OFS = 8'h72;
   localparam logic [7:0] RX_OUTPUT_EMPHASIS_CTRL_OFS = 8'h73;
   localparam logic [7:0] WARNING_FLAGS_MAIN_OFS      = 8'h74;
   localparam logic [7:0] WARNING_FLAGS_RX_POWER_OFS  = 8'h75;
   localparam logic [7:0] POWER_LEVEL_STATUS_CTRL_OFS = 8'h76;
   localparam logic [7:0] RECOVERY_LOCK_STATUS_OFS    = 8'h77;

   // Monitored quantities, in the order their flag pairs appear from the top bit down.
   localparam int MON_TEMP    = 0;
   localparam int MON_VCC     = 1;
   localparam int MON_BIAS    = 2;
   localparam int MON_TX_PWR  = 3;
   localparam int MON_RX_PWR  = 4;
   localparam int NUM_MON     = 5;
   localparam int MAIN_MON    = 4;

   // Field positions.
   localparam int RX_PWR_HIGH_BIT   = 7;
   localparam int RX_PWR_LOW_BIT    = 6;
   localparam int CODE_MSB          = 7;
   localparam int CODE_LSB          = 4;
   localparam int PWR_STATE_BIT     = 1;
   localparam int PWR_SELECT_BIT    = 0;
   localparam int TX_UNLOCK_BIT     = 1;
   localparam int RX_UNLOCK_BIT     = 0;

   // Code limits and reset values.
   localparam logic [3:0] EQ_CODE_MAX       = 4'hA;
   localparam logic [3:0] EQ_CODE_RESET     = 4'h0;
   localparam logic [3:0] EMPH_CODE_RESET   = 4'h0;
   localparam logic       PWR_SELECT_RESET  = 1'b0;
   localparam logic       PWR_STATE_VALUE   = 1'b0;
   localparam logic [7:0] READ_ZERO         = 8'h00;

   // Four thresholds of one monitored quantity.
   typedef struct packed {
      logic [15:0] high_alarm;
      logic [15:0] low_alarm;
      logic [15:0] high_warning;
      logic [15:0] low_warning;
   } limits_s;

   typedef limits_s [NUM_MON-1:0] limits_t;
   typedef logic [NUM_MON-1:0][15:0] values_t;

   // Byte access from the serial bus engine.
   typedef struct packed {
      logic       write;
      logic       read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } byte_req_s;

endpackage : diag_flag_pkg

// ---- core/threshold_compare.sv ----
// One monitored quantity held against its four alarm and warning thresholds.
`timescale 1ns/10ps
module threshold_compare
   import diag_flag_pkg::*;
#(
   parameter bit IS_SIGNED = 1'b0
) (
   input  wire logic [15:0] value,        // Real-time value
   input  wire limits_s     limits,       // Four thresholds
   output logic             high_alarm,   // Above high alarm threshold
   output logic             low_alarm,    // Below low alarm threshold
   output logic             high_warning, // Above high warning threshold
   output logic             low_warning   // Below low warning threshold
);

   // Flipping the sign bit turns a two's complement order into a plain unsigned one.
   logic [15:0] bias_flip;
   logic [15:0] v;
   logic [15:0] ha;
   logic [15:0] la;
   logic [15:0] hw;
   logic [15:0] lw;

   assign bias_flip = IS_SIGNED ? 16'h8000 : 16'h0000;
   assign v  = value ^ bias_flip;
   assign ha = limits.high_alarm ^ bias_flip;
   assign la = limits.low_alarm ^ bias_flip;
   assign hw = limits.high_warning ^ bias_flip;
   assign lw = limits.low_warning ^ bias_flip;

   assign high_alarm   = v > ha;
   assign low_alarm    = v < la;
   assign high_warning = v > hw;
   assign low_warning  = v < lw;

endmodule : threshold_compare

// ---- core/diag_flag_control_regs.sv ----
// Diagnostic alarm, warning, power level, lock status and equalization control bytes.
`timescale 1ns/10ps

// Behaviour
// (RULE1) alarm_flags_main bits 7/6: temperature above high / below low alarm threshold.
// (RULE2) alarm_flags_main bits 5/4: supply voltage above high / below low alarm threshold.
// (RULE3) alarm_flags_main bits 3/2: laser bias above high / below low alarm threshold.
// (RULE4) alarm_flags_main bits 1/0: transmit power above high / below low alarm threshold.
// (RULE5) alarm_flags_rx_power bits 7/6: receive power alarm flags; bits 5..0 reserved.
// (RULE6) warning_flags_main bits 7/6: temperature above high / below low warning threshold.
// (RULE7) warning_flags_main bits 5/4: supply voltage high / low warning flags.
// (RULE8) warning_flags_main bits 3/2: laser bias high / low warning flags.
// (RULE9) warning_flags_main bits 1/0: transmit power high / low warning flags.
// (RULE10) warning_flags_rx_power bits 7/6: receive power warning flags; bits 5..0 reserved.
// (RULE11) power_level_status_ctrl bit 1 always reads zero: lowest power class, one watt.
// (RULE12) power_level_status_ctrl bit 0 power select is stored but never changes operation.
// (RULE13) recovery_lock_status bits 1/0: transmit / receive recovery unlock, 1 = unlocked.
// (RULE14) tx_input_equalizer_ctrl bits 7..4 hold the host equalization code for input stage.
// (RULE15) Equalization codes 0..10 select 0..10 dB; codes above 10 are reserved.
// (RULE16) rx_output_emphasis_ctrl bits 7..4 hold the host emphasis code for output stage.
// (RULE17) Emphasis codes 0..7 select 0..7 dB; top bit set is vendor specific.
// (RULE18) Temperature compares as signed 16-bit values.
// (RULE19) Voltage, bias and power compare as unsigned 16-bit values.
// (RULE20) Flags follow the live comparison; reading has no side effect.
// (RULE21) Reserved bits read zero; writes to reserved or read-only bits are ignored.
module diag_flag_control_regs
   import diag_flag_pkg::*;
(
   input  wire logic       sys_clk,            // Management clock, 10 MHz
   input  wire logic       reset_n,            // Asynchronous reset, active low
   input  wire byte_req_s  bus_req,            // Byte access from the serial engine
   output logic [7:0]      bus_rdata,          // Read data, valid with bus_rdata_valid
   output logic            bus_rdata_valid,    // One-cycle pulse after a read
   output logic            bus_hit,            // Last access fell inside this group
   input  wire values_t    monitor_values,     // Real-time values per quantity
   input  wire limits_t    monitor_limits,     // Thresholds per quantity
   input  wire logic       transmit_unlock_in, // Raw loss-of-lock from transmit recovery
   input  wire logic       receive_unlock_in,  // Raw loss-of-lock from receive recovery
   output logic [3:0]      transmit_input_equalization_code, // Code to input stage
   output logic [3:0]      receive_output_emphasis_code,     // Code to output stage
   output logic            emphasis_vendor_mode,             // Emphasis code is vendor specific
   output logic [7:0]      alarm_flags,        // Alarm flag byte, main quantities
   output logic [1:0]      rx_alarm_flags,     // Receive power alarm flags, high then low
   output logic [7:0]      warning_flags,      // Warning flag byte, main quantities
   output logic [1:0]      rx_warning_flags,   // Receive power warning flags, high then low
   output logic            transmit_recovery_unlock_flag, // Synchronised transmit unlock
   output logic            receive_recovery_unlock_flag   // Synchronised receive unlock
);

   typedef struct packed {
      logic [7:0] alarm_main;
      logic [1:0] alarm_rx;
      logic [7:0] warn_main;
      logic [1:0] warn_rx;
      logic [3:0] eq_code;
      logic [3:0] emph_code;
      logic       emph_vendor;
      logic       pwr_select;
      logic       tx_unlock_meta;
      logic       tx_unlock_sync;
      logic       rx_unlock_meta;
      logic       rx_unlock_sync;
      logic [7:0] rdata;
      logic       rvalid;
      logic       hit;
   } state_s;

   state_s state_reg;
   state_s state_next;

   logic [NUM_MON-1:0] cmp_high_alarm;
   logic [NUM_MON-1:0] cmp_low_alarm;
   logic [NUM_MON-1:0] cmp_high_warning;
   logic [NUM_MON-1:0] cmp_low_warning;

   // Temperature is the only signed quantity.
   genvar g;
   generate
      for (g = 0; g < NUM_MON; g++) begin : g_mon
         threshold_compare #(
            .IS_SIGNED (g == MON_TEMP) // RULE18 RULE19
         ) u_cmp (
            .value        (monitor_values[g]),
            .limits       (monitor_limits[g]),
            .high_alarm   (cmp_high_alarm[g]),
            .low_alarm    (cmp_low_alarm[g]),
            .high_warning (cmp_high_warning[g]),
            .low_warning  (cmp_low_warning[g])
         );
      end
   endgenerate

   // Packs the high/low pairs of the four main quantities, temperature in the top pair.
   function automatic logic [7:0] pack_main(input logic [NUM_MON-1:0] hi,
                                            input logic [NUM_MON-1:0] lo);
      logic [7:0] b;
      b = 8'h00;
      for (int i = 0; i < MAIN_MON; i++) begin
         b[7 - 2*i] = hi[i];
         b[6 - 2*i] = lo[i];
      end
      return b;
   endfunction : pack_main

   // Read value of a byte; bits not listed stay zero.
   function automatic logic [7:0] read_byte(input state_s s, input logic [7:0] a);
      logic [7:0] b;
      b = READ_ZERO;
      case (a)
         ALARM_FLAGS_MAIN_OFS: begin
            b = s.alarm_main;
         end
         ALARM_FLAGS_RX_POWER_OFS: begin
            b[RX_PWR_HIGH_BIT] = s.alarm_rx[1]; // RULE5
            b[RX_PWR_LOW_BIT]  = s.alarm_rx[0]; // RULE5
         end
         TX_INPUT_EQUALIZER_CTRL_OFS: begin
            b[CODE_MSB:CODE_LSB] = s.eq_code; // RULE14 RULE21
         end
         RX_OUTPUT_EMPHASIS_CTRL_OFS: begin
            b[CODE_MSB:CODE_LSB] = s.emph_code; // RULE16 RULE21
         end
         WARNING_FLAGS_MAIN_OFS: begin
            b = s.warn_main;
         end
         WARNING_FLAGS_RX_POWER_OFS: begin
            b[RX_PWR_HIGH_BIT] = s.warn_rx[1]; // RULE10
            b[RX_PWR_LOW_BIT]  = s.warn_rx[0]; // RULE10
         end
         POWER_LEVEL_STATUS_CTRL_OFS: begin
            b[PWR_STATE_BIT]  = PWR_STATE_VALUE; // RULE11
            b[PWR_SELECT_BIT] = s.pwr_select;
         end
         RECOVERY_LOCK_STATUS_OFS: begin
            b[TX_UNLOCK_BIT] = s.tx_unlock_sync; // RULE13
            b[RX_UNLOCK_BIT] = s.rx_unlock_sync; // RULE13
         end
         default: begin
            b = READ_ZERO;
         end
      endcase
      return b;
   endfunction : read_byte

   function automatic logic in_group(input logic [7:0] a);
      return (a >= ALARM_FLAGS_MAIN_OFS) && (a <= RECOVERY_LOCK_STATUS_OFS);
   endfunction : in_group

   always_comb begin
      state_next = state_reg;

      // Flags are recomputed every cycle, so a value back inside its limits clears them.
      state_next.alarm_main = pack_main(cmp_high_alarm, cmp_low_alarm); // RULE1 RULE2 RULE3 RULE4 RULE20
      state_next.warn_main  = pack_main(cmp_high_warning, cmp_low_warning); // RULE6 RULE7 RULE8 RULE9 RULE20
      state_next.alarm_rx   = {cmp_high_alarm[MON_RX_PWR], cmp_low_alarm[MON_RX_PWR]}; // RULE5
      state_next.warn_rx    = {cmp_high_warning[MON_RX_PWR], cmp_low_warning[MON_RX_PWR]}; // RULE10

      // The lock inputs come from analogue recovery units on no clock of ours.
      state_next.tx_unlock_meta = transmit_unlock_in;
      state_next.tx_unlock_sync = state_reg.tx_unlock_meta; // RULE13
      state_next.rx_unlock_meta = receive_unlock_in;
      state_next.rx_unlock_sync = state_reg.rx_unlock_meta; // RULE13

      state_next.rvalid = 1'b0;
      if (bus_req.read || bus_req.write) begin
         state_next.hit = in_group(bus_req.addr);
      end

      // A read only samples state; nothing is cleared by it.
      if (bus_req.read) begin
         state_next.rdata  = read_byte(state_reg, bus_req.addr); // RULE20 RULE21
         state_next.rvalid = 1'b1;
      end

      // Writes to flag and status bytes and to low reserved nibbles are dropped.
      if (bus_req.write) begin
         case (bus_req.addr)
            TX_INPUT_EQUALIZER_CTRL_OFS: begin
               // A reserved code would leave the input stage undefined, so the old code stays.
               if (bus_req.wdata[CODE_MSB:CODE_LSB] <= EQ_CODE_MAX) begin // RULE15
                  state_next.eq_code = bus_req.wdata[CODE_MSB:CODE_LSB]; // RULE14
               end
            end
            RX_OUTPUT_EMPHASIS_CTRL_OFS: begin
               state_next.emph_code = bus_req.wdata[CODE_MSB:CODE_LSB]; // RULE16
            end
            POWER_LEVEL_STATUS_CTRL_OFS: begin
               // Kept for read-back only; no logic looks at it.
               state_next.pwr_select = bus_req.wdata[PWR_SELECT_BIT]; // RULE12
            end
            default: begin
               state_next.pwr_select = state_reg.pwr_select; // RULE21
            end
         endcase
      end

      state_next.emph_vendor = state_next.emph_code[3]; // RULE17
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= '{
            alarm_main     : 8'h00,
            alarm_rx       : 2'h0,
            warn_main      : 8'h00,
            warn_rx        : 2'h0,
            eq_code        : EQ_CODE_RESET,
            emph_code      : EMPH_CODE_RESET,
            emph_vendor    : 1'b0,
            pwr_select     : PWR_SELECT_RESET,
            tx_unlock_meta : 1'b0,
            tx_unlock_sync : 1'b0,
            rx_unlock_meta : 1'b0,
            rx_unlock_sync : 1'b0,
            rdata          : READ_ZERO,
            rvalid         : 1'b0,
            hit            : 1'b0
         };
      end else begin
         state_reg <= state_next;
      end
   end

   assign bus_rdata                        = state_reg.rdata;
   assign bus_rdata_valid                  = state_reg.rvalid;
   assign bus_hit                          = state_reg.hit;
   assign transmit_input_equalization_code = state_reg.eq_code; // RULE14
   assign receive_output_emphasis_code     = state_reg.emph_code; // RULE16
   assign emphasis_vendor_mode             = state_reg.emph_vendor; // RULE17
   assign alarm_flags                      = state_reg.alarm_main;
   assign rx_alarm_flags                   = state_reg.alarm_rx;
   assign warning_flags                    = state_reg.warn_main;
   assign rx_warning_flags                 = state_reg.warn_rx;
   assign transmit_recovery_unlock_flag    = state_reg.tx_unlock_sync;
   assign receive_recovery_unlock_flag     = state_reg.rx_unlock_sync;

endmodule : diag_flag_control_regs

// ---- testbench/diag_flag_control_regs_sva.sv ----
// Concurrent checks on the ports of the diagnostic flag and control group.
`timescale 1ns/10ps
module diag_flag_control_regs_sva
   import diag_flag_pkg::*;
(
   input wire logic       sys_clk,                          // Clock
   input wire logic       reset_n,                          // Reset, active low
   input wire byte_req_s  bus_req,                          // Byte access
   input wire logic [7:0] bus_rdata,                        // Read data
   input wire logic       bus_rdata_valid,                  // Read answer
   input wire logic       bus_hit,                          // Access in group
   input wire values_t    monitor_values,                   // Live values
   input wire limits_t    monitor_limits,                   // Thresholds
   input wire logic       transmit_unlock_in,               // Raw unlock
   input wire logic [3:0] transmit_input_equalization_code, // Input stage code
   input wire logic [3:0] receive_output_emphasis_code,     // Output stage code
   input wire logic       emphasis_vendor_mode,             // Vendor emphasis
   input wire logic [7:0] alarm_flags,                      // Alarm byte
   input wire logic [1:0] rx_warning_flags,                 // Receive warnings
   input wire logic       transmit_recovery_unlock_flag     // Synced unlock
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   logic temp_hi;
   logic rx_lo;
   logic eq_wr;
   // Temperature is two's complement, so an unsigned compare would misread cold as hot.
   assign temp_hi = $signed(monitor_values[MON_TEMP]) > $signed(monitor_limits[MON_TEMP].high_alarm);
   assign rx_lo = monitor_values[MON_RX_PWR] < monitor_limits[MON_RX_PWR].low_warning;
   assign eq_wr = bus_req.write && bus_req.addr == TX_INPUT_EQUALIZER_CTRL_OFS;
   sequence read_taken;
      bus_req.read;
   endsequence
   sequence unlock_held;
      transmit_unlock_in ##1 transmit_unlock_in;
   endsequence
   a_read_answer: assert property (read_taken |=> bus_rdata_valid)
      else $error("read not answered next cycle");
   a_valid_only_read: assert property (!bus_req.read |=> !bus_rdata_valid)
      else $error("read answer without a read");
   a_hit_in_group: assert property ((bus_req.read || bus_req.write)
      |=> bus_hit == ($past(bus_req.addr[7:3]) == 5'h0E))
      else $error("group hit wrong");
   a_temp_high_alarm: assert property (1'b1 |=> alarm_flags[7] == $past(temp_hi))
      else $error("temperature high alarm wrong");
   a_rx_low_warn: assert property (1'b1 |=> rx_warning_flags[0] == $past(rx_lo))
      else $error("receive low warning wrong");
   a_eq_code_taken: assert property (eq_wr && bus_req.wdata[7:4] <= EQ_CODE_MAX
      |=> transmit_input_equalization_code == $past(bus_req.wdata[7:4]))
      else $error("equalization code not taken");
   a_eq_reserved_kept: assert property (eq_wr && bus_req.wdata[7:4] > EQ_CODE_MAX
      |=> $stable(transmit_input_equalization_code))
      else $error("reserved equalization code taken");
   a_pwr_state_zero: assert property (bus_req.read && bus_req.addr == POWER_LEVEL_STATUS_CTRL_OFS
      |=> bus_rdata[7:1] == 7'h00)
      else $error("power level byte upper bits set");
   a_tx_unlock_sync: assert property (unlock_held |=> transmit_recovery_unlock_flag)
      else $error("transmit unlock not shown");
   a_vendor_mode: assert property (emphasis_vendor_mode == receive_output_emphasis_code[3])
      else $error("vendor emphasis flag wrong");
endmodule : diag_flag_control_regs_sva

bind diag_flag_control_regs diag_flag_control_regs_sva u_diag_flag_control_regs_sva (
   .sys_clk(sys_clk), .reset_n(reset_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
   .bus_rdata_valid(bus_rdata_valid), .bus_hit(bus_hit), .monitor_values(monitor_values),
   .monitor_limits(monitor_limits), .transmit_unlock_in(transmit_unlock_in),
   .transmit_input_equalization_code(transmit_input_equalization_code),
   .receive_output_emphasis_code(receive_output_emphasis_code),
   .emphasis_vendor_mode(emphasis_vendor_mode), .alarm_flags(alarm_flags),
   .rx_warning_flags(rx_warning_flags),
   .transmit_recovery_unlock_flag(transmit_recovery_unlock_flag));

// ---- testbench/host_bus_model.sv ----
// Host side of the byte access path: single reads and writes.
`timescale 1ns/10ps
module host_bus_model
   import diag_flag_pkg::*;
(
   input  wire logic       sys_clk,        // Clock
   output byte_req_s       bus_req,        // Byte access to the group
   input  wire logic [7:0] bus_rdata,      // Read data
   input  wire logic       bus_rdata_valid // Read answer
);
   initial bus_req = '0;
   // Released address and data carry the inverse, so a stale value can never pass.
   task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
      @(posedge sys_clk);
      bus_req <= '{write: 1'b1, read: 1'b0, addr: addr, wdata: data};
      @(posedge sys_clk);
      bus_req <= '{write: 1'b0, read: 1'b0, addr: ~addr, wdata: ~data};
   endtask : write_byte
   // The answer stands for one cycle just after the taking edge.
   task automatic read_byte(input logic [7:0] addr, output logic [7:0] data, output bit ok);
      @(posedge sys_clk);
      bus_req <= '{write: 1'b0, read: 1'b1, addr: addr, wdata: 8'h00};
      @(posedge sys_clk);
      bus_req <= '{write: 1'b0, read: 1'b0, addr: ~addr, wdata: 8'hFF};
      #1;
      ok = (bus_rdata_valid === 1'b1);
      data = bus_rdata;
   endtask : read_byte
endmodule : host_bus_model

// ---- testbench/diag_flag_control_regs_test.sv ----
// Self-checking bench for the diagnostic flag and control group.
`timescale 1ns/10ps
module diag_flag_control_regs_test
   import diag_flag_pkg::*;
;
   logic       sys_clk = 1'b0;
   logic       reset_n = 1'b0;
   byte_req_s  bus_req;
   logic [7:0] bus_rdata;
   logic       bus_rdata_valid;
   logic       bus_hit;
   values_t    monitor_values = {NUM_MON{16'h2000}};
   limits_t    monitor_limits = {NUM_MON{64'h4000_1000_3000_1800}};
   logic       transmit_unlock_in = 1'b0;
   logic       receive_unlock_in = 1'b0;
   logic [3:0] eq_code;
   logic [3:0] emph_code;
   logic       vendor;
   logic [7:0] alarm_flags;
   logic [7:0] warning_flags;
   logic [1:0] rx_alarm_flags;
   logic [1:0] rx_warning_flags;
   logic       tx_flag;
   logic       rx_flag;
   int         fails = 0;
   int         compares = 0;

   always #50 sys_clk = ~sys_clk;

   diag_flag_control_regs u_diag_flag_control_regs (
      .sys_clk(sys_clk), .reset_n(reset_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
      .bus_rdata_valid(bus_rdata_valid), .bus_hit(bus_hit), .monitor_values(monitor_values),
      .monitor_limits(monitor_limits), .transmit_unlock_in(transmit_unlock_in),
      .receive_unlock_in(receive_unlock_in), .transmit_input_equalization_code(eq_code),
      .receive_output_emphasis_code(emph_code), .emphasis_vendor_mode(vendor),
      .alarm_flags(alarm_flags), .rx_alarm_flags(rx_alarm_flags),
      .warning_flags(warning_flags), .rx_warning_flags(rx_warning_flags),
      .transmit_recovery_unlock_flag(tx_flag), .receive_recovery_unlock_flag(rx_flag));

   host_bus_model u_host_bus_model (
      .sys_clk(sys_clk), .bus_req(bus_req), .bus_rdata(bus_rdata),
      .bus_rdata_valid(bus_rdata_valid));

   task automatic report_and_stop;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] data;
      bit         ok;
      u_host_bus_model.read_byte(addr, data, ok);
      check($sformatf("byte %h", addr), exp, data);
      if (!ok) begin
         fails++;
         report_and_stop();
      end
   endtask : rd

   task automatic set_value(input int m, input logic [15:0] v);
      @(posedge sys_clk);
      monitor_values[m] <= v;
      repeat (2) @(posedge sys_clk);
   endtask : set_value

   // Equal to a threshold must not flag, so 4000h and 1000h are the boundary cases.
   task automatic test_flags;
      logic [15:0] v [4] = '{16'h5000, 16'h4000, 16'h1000, 16'h0800};
      logic [1:0]  ea [4] = '{2'b10, 2'b00, 2'b00, 2'b01};
      logic [1:0]  ew [4] = '{2'b10, 2'b10, 2'b01, 2'b01};
      logic [7:0]  xa;
      logic [7:0]  xw;
      logic [1:0]  xra;
      logic [1:0]  xrw;
      for (int m = 0; m < NUM_MON; m++) begin
         for (int k = 0; k < 4; k++) begin
            set_value(m, v[k]);
            xa = (m < MAIN_MON) ? 8'(ea[k]) << (6 - 2 * m) : 8'h00;
            xw = (m < MAIN_MON) ? 8'(ew[k]) << (6 - 2 * m) : 8'h00;
            xra = (m == MON_RX_PWR) ? ea[k] : 2'b00;
            xrw = (m == MON_RX_PWR) ? ew[k] : 2'b00;
            rd(ALARM_FLAGS_MAIN_OFS, xa);
            rd(ALARM_FLAGS_RX_POWER_OFS, (m == MON_RX_PWR) ? {ea[k], 6'h00} : 8'h00);
            rd(WARNING_FLAGS_MAIN_OFS, xw);
            rd(WARNING_FLAGS_RX_POWER_OFS, (m == MON_RX_PWR) ? {ew[k], 6'h00} : 8'h00);
            check("alarm out", xa, alarm_flags);
            check("warning out", xw, warning_flags);
            check("rx alarm out", {6'h00, xra}, {6'h00, rx_alarm_flags});
            check("rx warning out", {6'h00, xrw}, {6'h00, rx_warning_flags});
         end
         set_value(m, 16'h2000);
         rd(ALARM_FLAGS_MAIN_OFS, 8'h00);
      end
      set_value(MON_TEMP, 16'hF000);
      rd(ALARM_FLAGS_MAIN_OFS, 8'h40);
      set_value(MON_TEMP, 16'h2000);
      set_value(MON_VCC, 16'hF000);
      rd(WARNING_FLAGS_MAIN_OFS, 8'h20);
      set_value(MON_VCC, 16'h2000);
   endtask : test_flags

   // Reserved equalization codes are dropped, so code ten stays after 11 to 15.
   task automatic test_codes;
      logic [3:0] x;
      for (int c = 0; c < 16; c++) begin
         x = (c > 10) ? EQ_CODE_MAX : 4'(c);
         u_host_bus_model.write_byte(TX_INPUT_EQUALIZER_CTRL_OFS, {4'(c), 4'hF});
         u_host_bus_model.write_byte(RX_OUTPUT_EMPHASIS_CTRL_OFS, {4'(c), 4'h5});
         rd(TX_INPUT_EQUALIZER_CTRL_OFS, {x, 4'h0});
         rd(RX_OUTPUT_EMPHASIS_CTRL_OFS, {4'(c), 4'h0});
         check("eq code", {4'h0, x}, {4'h0, eq_code});
         check("emph code", 8'(c), {4'h0, emph_code});
         check("vendor", {7'h00, c[3]}, {7'h00, vendor});
         check("hit", 8'h01, {7'h00, bus_hit});
      end
   endtask : test_codes

   task automatic test_ro_writes;
      logic [7:0] ro [6] = '{8'h70, 8'h71, 8'h74, 8'h75, 8'h77, 8'h78};
      for (int i = 0; i < 6; i++) begin
         u_host_bus_model.write_byte(ro[i], 8'hFF);
         rd(ro[i], 8'h00);
      end
      check("hit", 8'h00, {7'h00, bus_hit});
      u_host_bus_model.write_byte(POWER_LEVEL_STATUS_CTRL_OFS, 8'hFF);
      rd(POWER_LEVEL_STATUS_CTRL_OFS, 8'h01);
      check("eq kept", {4'h0, EQ_CODE_MAX}, {4'h0, eq_code});
      u_host_bus_model.write_byte(POWER_LEVEL_STATUS_CTRL_OFS, 8'h00);
      rd(POWER_LEVEL_STATUS_CTRL_OFS, 8'h00);
   endtask : test_ro_writes

   task automatic test_unlock;
      logic [1:0] p [3] = '{2'b10, 2'b01, 2'b00};
      for (int i = 0; i < 3; i++) begin
         @(posedge sys_clk);
         {transmit_unlock_in, receive_unlock_in} <= p[i];
         repeat (3) @(posedge sys_clk);
         rd(RECOVERY_LOCK_STATUS_OFS, {6'h00, p[i]});
         check("unlock out", {6'h00, p[i]}, {6'h00, tx_flag, rx_flag});
      end
   endtask : test_unlock

   // A reset in mid-run must bring the written codes back to none.
   task automatic test_reset;
      @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check("reset eq", 8'h00, {4'h0, eq_code});
      check("reset emph", 8'h00, {3'h0, vendor, emph_code});
      reset_n <= 1'b1;
      rd(RX_OUTPUT_EMPHASIS_CTRL_OFS, 8'h00);
      rd(TX_INPUT_EQUALIZER_CTRL_OFS, 8'h00);
   endtask : test_reset

   initial begin
      repeat (8) @(posedge sys_clk);
      reset_n <= 1'b1;
      for (int a = 8'h70; a <= 8'h78; a++) begin
         rd(8'(a), 8'h00);
      end
      test_flags();
      test_codes();
      test_ro_writes();
      test_unlock();
      test_reset();
      report_and_stop();
   end
endmodule : diag_flag_control_regs_test
